// *** hw/ilc_top.sv ***
// In-band loop code generator and up/down detectors behind an AXI4-Lite slave.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Contract
// - Receive length field n means n+1 bits.
// - Transmit pattern register sent MSB first.
// - Up code first bit is bit seven.
// - Up code compares only top L bits.
// - Up and down pattern registers exist.
// - Down code first bit is bit seven.
// - Down code compares only top L bits.
// - Transmit length field selects five to eight.
// - Loop enable sends pattern; framing bit overwrites.
// - Flag set after 48 ms, errors tolerated.
module ilc_top
  import ilc_pkg::*;
#(
  parameter int INTEG_CYCLES = ILC_INTEG_CYCLES
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic [ILC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ILC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  txPcmData,
  input  wire logic                  txBitStrobe,
  input  wire logic                  txFramingSlot,
  input  wire logic                  txFramingBit,
  input  wire logic                  rxLineData,
  input  wire logic                  rxBitStrobe,
  output logic                       txLineData,
  output logic                       irq
);
  logic [7:0]            lenCtl;
  logic [7:0]            next_lenCtl;
  logic [7:0]            txPat;
  logic [7:0]            next_txPat;
  logic [7:0]            upPat;
  logic [7:0]            next_upPat;
  logic [7:0]            dnPat;
  logic [7:0]            next_dnPat;
  logic [1:0]            ctrl;
  logic [1:0]            next_ctrl;
  logic [1:0]            status;
  logic [1:0]            next_status;
  logic [1:0]            mask;
  logic [1:0]            next_mask;
  logic [1:0]            clrBits;
  logic                  next_irq;
  logic                  awHeld;
  logic                  next_awHeld;
  logic [ILC_ADDR_W-1:0] awAddr;
  logic [ILC_ADDR_W-1:0] next_awAddr;
  logic                  wHeld;
  logic                  next_wHeld;
  logic [7:0]            wData;
  logic [7:0]            next_wData;
  logic                  wLane0;
  logic                  next_wLane0;
  logic                  next_awready;
  logic                  next_wready;
  logic                  next_bvalid;
  logic [1:0]            next_bresp;
  logic                  next_arready;
  logic                  next_rvalid;
  logic [31:0]           next_rdata;
  logic [1:0]            next_rresp;
  logic [8:0]            wrDec;
  logic [8:0]            rdDec;
  logic [7:0]            rdByte;
  logic [2:0]            txIdx;
  logic [2:0]            next_txIdx;
  logic [2:0]            txLast;
  logic                  next_txData;
  logic                  txEn;
  logic                  fbitIns;
  logic                  patBit;

  ilc_det_if upIf ();
  ilc_det_if dnIf ();

  assign upIf.pattern  = upPat;
  assign upIf.lenSel   = lenCtl[ILC_UPLEN_LSB +: 3];
  assign upIf.rxBit    = rxLineData;
  assign upIf.rxStrobe = rxBitStrobe;
  assign dnIf.pattern  = dnPat;
  assign dnIf.lenSel   = lenCtl[ILC_DNLEN_LSB +: 3];
  assign dnIf.rxBit    = rxLineData;
  assign dnIf.rxStrobe = rxBitStrobe;

  ilc_detector #(.INTEG_CYCLES(INTEG_CYCLES)) upDet (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .det     (upIf.det)
  );

  ilc_detector #(.INTEG_CYCLES(INTEG_CYCLES)) dnDet (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .det     (dnIf.det)
  );

  // Register bus: address and data are taken in either order; the response needs both.
  always_comb
  begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wLane0 = wLane0;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    next_lenCtl = lenCtl;
    next_txPat  = txPat;
    next_upPat  = upPat;
    next_dnPat  = dnPat;
    next_ctrl   = ctrl;
    next_mask   = mask;
    clrBits     = 2'h0;
    wrDec       = ilc_decode(awAddr);
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHeld  = 1'b1;
      next_wData  = s_axi_wdata[7:0];
      next_wLane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (awHeld && wHeld && !s_axi_bvalid)
    begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = wrDec[8] ? ILC_RESP_OKAY : ILC_RESP_SLVERR;
      if (wrDec[8] && wLane0)
      begin
        unique case (wrDec[7:0])
          ILC_IDX_LENCTL: next_lenCtl = wData;
          ILC_IDX_TXPAT:  next_txPat  = wData;
          ILC_IDX_UPPAT:  next_upPat  = wData;
          ILC_IDX_DNPAT:  next_dnPat  = wData;
          ILC_IDX_CTRL:   next_ctrl   = wData[1:0];
          ILC_IDX_STATUS: clrBits     = wData[1:0];
          ILC_IDX_MASK:   next_mask   = wData[1:0];
          default:        clrBits     = 2'h0;
        endcase
      end
    end
    next_awready = !next_awHeld && !next_bvalid;
    next_wready  = !next_wHeld && !next_bvalid;
    // A detection in the same cycle as its clear keeps the bit set.
    next_status  = (status & ~clrBits) | {dnIf.hit, upIf.hit};
    next_irq     = |(next_status & next_mask);
  end

  always_comb
  begin
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    rdDec        = ilc_decode(s_axi_araddr);
    rdByte       = 8'h00;
    unique case (rdDec[7:0])
      ILC_IDX_LENCTL: rdByte = lenCtl;
      ILC_IDX_TXPAT:  rdByte = txPat;
      ILC_IDX_UPPAT:  rdByte = upPat;
      ILC_IDX_DNPAT:  rdByte = dnPat;
      ILC_IDX_CTRL:   rdByte = {6'h00, ctrl};
      ILC_IDX_STATUS: rdByte = {6'h00, status};
      ILC_IDX_MASK:   rdByte = {6'h00, mask};
      ILC_IDX_LIVE:   rdByte = {6'h00, dnIf.present, upIf.present};
      default:        rdByte = 8'h00;
    endcase
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rdata  = rdDec[8] ? {24'h000000, rdByte} : 32'h00000000;
      next_rresp  = rdDec[8] ? ILC_RESP_OKAY : ILC_RESP_SLVERR;
    end
    next_arready = !next_rvalid;
  end

  // Generator: the index freezes at zero while disabled, so a new code starts with bit seven.
  always_comb
  begin
    txEn        = ctrl[ILC_CTRL_TXEN];
    fbitIns     = txFramingSlot && !ctrl[ILC_CTRL_FDIS];
    txLast      = ilc_tx_last(lenCtl[ILC_TXLEN_LSB +: 2]);
    patBit      = txPat[3'h7 - txIdx];
    next_txIdx  = txIdx;
    next_txData = txLineData;
    if (!txEn)
    begin
      next_txIdx = 3'h0;
      if (txBitStrobe)
      begin
        next_txData = txPcmData;
      end
    end
    else if (txBitStrobe)
    begin
      // The framing bit replaces a pattern bit but the pattern keeps its phase.
      next_txIdx  = (txIdx >= txLast) ? 3'h0 : txIdx + 3'h1;
      next_txData = fbitIns ? txFramingBit : patBit;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lenCtl        <= ILC_RST_LENCTL;
      txPat         <= ILC_RST_PAT;
      upPat         <= ILC_RST_PAT;
      dnPat         <= ILC_RST_PAT;
      ctrl          <= ILC_RST_CTRL;
      mask          <= ILC_RST_MASK;
      status        <= 2'h0;
      irq           <= 1'b0;
      awHeld        <= 1'b0;
      awAddr        <= '0;
      wHeld         <= 1'b0;
      wData         <= 8'h00;
      wLane0        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ILC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= ILC_RESP_OKAY;
      txIdx         <= 3'h0;
      txLineData    <= 1'b0;
    end
    else
    begin
      lenCtl        <= next_lenCtl;
      txPat         <= next_txPat;
      upPat         <= next_upPat;
      dnPat         <= next_dnPat;
      ctrl          <= next_ctrl;
      mask          <= next_mask;
      status        <= next_status;
      irq           <= next_irq;
      awHeld        <= next_awHeld;
      awAddr        <= next_awAddr;
      wHeld         <= next_wHeld;
      wData         <= next_wData;
      wLane0        <= next_wLane0;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      txIdx         <= next_txIdx;
      txLineData    <= next_txData;
    end
  end

  sequence s_sent_pattern;
    txLineData == $past(patBit);
  endsequence

  property p_tx_pattern;
    @(posedge clk_sys) disable iff (!rst_b) txEn && txBitStrobe && !fbitIns |=> s_sent_pattern;
  endproperty
  a_tx_pattern: assert property (p_tx_pattern) else $error("Wrong pattern bit sent.");

  property p_tx_wrap;
    @(posedge clk_sys) disable iff (!rst_b) txEn && txBitStrobe && (txIdx >= txLast) |=> txIdx == 3'h0;
  endproperty
  a_tx_wrap: assert property (p_tx_wrap) else $error("Pattern did not wrap at length.");

  property p_fbit;
    @(posedge clk_sys) disable iff (!rst_b) txEn && txBitStrobe && fbitIns |=> txLineData == $past(txFramingBit);
  endproperty
  a_fbit: assert property (p_fbit) else $error("Framing bit not inserted.");

  property p_event_sticky;
    @(posedge clk_sys) disable iff (!rst_b) upIf.hit |=> status[ILC_EV_UP] ##1 (status[ILC_EV_UP] || $past(clrBits[0]));
  endproperty
  a_event_sticky: assert property (p_event_sticky) else $error("Up detect event lost.");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_b) irq == (|(status & mask));
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt does not follow masked status.");
endmodule : ilc_top

// *** hw/ilc_pkg.sv ***
// Constants, register map and helper functions of the in-band loop code block.
package ilc_pkg;
  localparam int          ILC_ADDR_W        = 8;
  localparam logic [7:0]  ILC_IDX_LENCTL    = 8'h12;
  localparam logic [7:0]  ILC_IDX_TXPAT     = 8'h13;
  localparam logic [7:0]  ILC_IDX_UPPAT     = 8'h14;
  localparam logic [7:0]  ILC_IDX_DNPAT     = 8'h15;
  localparam logic [7:0]  ILC_IDX_CTRL      = 8'h16;
  localparam logic [7:0]  ILC_IDX_STATUS    = 8'h17;
  localparam logic [7:0]  ILC_IDX_MASK      = 8'h18;
  localparam logic [7:0]  ILC_IDX_LIVE      = 8'h19;
  localparam int          ILC_TXLEN_LSB     = 6;
  localparam int          ILC_UPLEN_LSB     = 3;
  localparam int          ILC_DNLEN_LSB     = 0;
  localparam int          ILC_CTRL_TXEN     = 0;
  localparam int          ILC_CTRL_FDIS     = 1;
  localparam int          ILC_EV_UP         = 0;
  localparam int          ILC_EV_DN         = 1;
  localparam logic [7:0]  ILC_RST_LENCTL    = 8'h00;
  localparam logic [7:0]  ILC_RST_PAT       = 8'h00;
  localparam logic [1:0]  ILC_RST_CTRL      = 2'h0;
  localparam logic [1:0]  ILC_RST_MASK      = 2'h0;
  localparam int          ILC_CLK_PERIOD_NS = 4;
  localparam int          ILC_INTEG_MS      = 48;
  localparam int          ILC_INTEG_CYCLES  = ILC_INTEG_MS * 1000000 / ILC_CLK_PERIOD_NS;
  localparam int          ILC_BITS_PER_ERR  = 100;
  localparam logic [15:0] ILC_ERR_SLACK     = 16'h0002;
  localparam logic [1:0]  ILC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  ILC_RESP_SLVERR   = 2'h2;

  // Last pattern index for the two-bit transmit length selection.
  function automatic logic [2:0] ilc_tx_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: ilc_tx_last = 3'h4;
      2'h1: ilc_tx_last = 3'h5;
      2'h2: ilc_tx_last = 3'h6;
      2'h3: ilc_tx_last = 3'h7;
    endcase
  endfunction : ilc_tx_last

  // Returns {hit, index}; only aligned words inside the map hit.
  function automatic logic [8:0] ilc_decode(input logic [ILC_ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = {2'h0, addr[7:2]};
    ilc_decode = {(addr[1:0] == 2'h0) && (idx >= ILC_IDX_LENCTL) && (idx <= ILC_IDX_LIVE), idx};
  endfunction : ilc_decode
endpackage : ilc_pkg

// *** hw/ilc_det_if.sv ***
// Configuration and result signals between the top and one code detector.
`timescale 1ns/1ps
interface ilc_det_if;
  logic [7:0] pattern;
  logic [2:0] lenSel;
  logic       rxBit;
  logic       rxStrobe;
  logic       hit;
  logic       present;
  modport det (input pattern, input lenSel, input rxBit, input rxStrobe, output hit, output present);
  modport ctl (output pattern, output lenSel, output rxBit, output rxStrobe, input hit, input present);
endinterface : ilc_det_if

// *** hw/ilc_detector.sv ***
// Repeating code detector with error-tolerant integration window.
`timescale 1ns/1ps
module ilc_detector
  import ilc_pkg::*;
#(
  parameter int INTEG_CYCLES = ILC_INTEG_CYCLES
)
(
  input wire logic  clk_sys,
  input wire logic  rst_b,
  ilc_det_if.det    det
);
  localparam int            TW         = $clog2(INTEG_CYCLES + 1);
  localparam logic [TW-1:0] TIMER_LAST = TW'(INTEG_CYCLES - 1);
  localparam logic [6:0]    MOD_LAST   = 7'(ILC_BITS_PER_ERR - 1);

  logic [2:0]    phase;
  logic [2:0]    next_phase;
  logic [TW-1:0] timer;
  logic [TW-1:0] next_timer;
  logic [6:0]    bitMod;
  logic [6:0]    next_bitMod;
  logic [15:0]   allow;
  logic [15:0]   next_allow;
  logic [15:0]   errCnt;
  logic [15:0]   next_errCnt;
  logic [15:0]   errSum;
  logic          present;
  logic          next_present;
  logic          hit;
  logic          next_hit;
  logic          miss;
  logic          restart;

  always_comb
  begin
    next_phase   = phase;
    next_timer   = timer + TW'(1);
    next_bitMod  = bitMod;
    next_allow   = allow;
    next_errCnt  = errCnt;
    next_present = present;
    next_hit     = 1'b0;
    miss         = det.rxBit != det.pattern[3'h7 - phase];
    errSum       = errCnt + {15'h0, det.rxStrobe & miss};
    // One error per hundred bits is tolerated; the slack absorbs early errors.
    restart      = det.rxStrobe && (errSum > (allow + ILC_ERR_SLACK));
    if (det.rxStrobe)
    begin
      next_phase  = (phase >= det.lenSel) ? 3'h0 : phase + 3'h1;
      next_errCnt = errSum;
      if (bitMod == MOD_LAST)
      begin
        next_bitMod = 7'h0;
        next_allow  = allow + 16'h0001;
      end
      else
      begin
        next_bitMod = bitMod + 7'h1;
      end
    end
    if (restart)
    begin
      // Holding the phase slips alignment one bit, so the search walks all rotations.
      next_phase   = phase;
      next_timer   = '0;
      next_errCnt  = 16'h0;
      next_allow   = 16'h0;
      next_bitMod  = 7'h0;
      next_present = 1'b0;
    end
    else if (timer == TIMER_LAST)
    begin
      next_hit     = 1'b1;
      next_present = 1'b1;
      next_timer   = '0;
      next_errCnt  = 16'h0;
      next_allow   = 16'h0;
      next_bitMod  = 7'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase   <= 3'h0;
      timer   <= '0;
      bitMod  <= 7'h0;
      allow   <= 16'h0;
      errCnt  <= 16'h0;
      present <= 1'b0;
      hit     <= 1'b0;
    end
    else
    begin
      phase   <= next_phase;
      timer   <= next_timer;
      bitMod  <= next_bitMod;
      allow   <= next_allow;
      errCnt  <= next_errCnt;
      present <= next_present;
      hit     <= next_hit;
    end
  end

  assign det.hit     = hit;
  assign det.present = present;

  sequence s_cleared;
    !present && (timer == '0) && (errCnt == 16'h0);
  endsequence

  property p_restart;
    @(posedge clk_sys) disable iff (!rst_b) restart |=> s_cleared ##1 (timer == TW'(1));
  endproperty
  a_restart: assert property (p_restart) else $error("Detector did not restart integration.");

  property p_integ;
    @(posedge clk_sys) disable iff (!rst_b) (timer == TIMER_LAST) && !restart |=> hit && present ##1 !hit;
  endproperty
  a_integ: assert property (p_integ) else $error("Detect flag not raised at window end.");

  property p_phase;
    @(posedge clk_sys) disable iff (!rst_b) $stable(det.lenSel) && (phase <= det.lenSel) |=> phase <= $past(det.lenSel);
  endproperty
  a_phase: assert property (p_phase) else $error("Pattern phase beyond length.");

  property p_match;
    @(posedge clk_sys) disable iff (!rst_b)
      det.rxStrobe && !miss && !restart && (timer != TIMER_LAST) |=> errCnt == $past(errCnt);
  endproperty
  a_match: assert property (p_match) else $error("Matching bit counted as error.");
endmodule : ilc_detector

// *** verification/ilc_remote_end.sv ***
// Remote line equipment that streams a repeating loop code into the receive side.
`timescale 1ns/1ps
module ilc_remote_end
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic [7:0] codeByte,
  input wire logic [3:0] codeLen,
  input wire logic [7:0] errEvery,
  input wire logic       corrupt,
  output logic           rxLineData,
  output logic           rxBitStrobe
);
  logic [2:0] phase;
  logic [7:0] count;
  logic       errNow;

  assign errNow = corrupt || (errEvery != 8'h00 && count == errEvery);

  // One bit every second cycle; between bits the line shows the inverse of the last bit.
  // A held value would let a detector that samples off the strobe pass by luck.
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase       <= 3'h0;
      count       <= 8'h01;
      rxBitStrobe <= 1'b0;
      rxLineData  <= 1'b0;
    end
    else if (rxBitStrobe)
    begin
      rxBitStrobe <= 1'b0;
      rxLineData  <= ~rxLineData;
    end
    else
    begin
      rxBitStrobe <= 1'b1;
      rxLineData  <= codeByte[3'h7 - phase] ^ errNow;
      phase       <= ({1'b0, phase} + 4'h1 >= codeLen) ? 3'h0 : phase + 3'h1;
      count       <= errNow ? 8'h01 : count + 8'h01;
    end
  end
endmodule : ilc_remote_end

// *** verification/inband_loop_code_gen_detect_test.sv ***
// Self-checking bench for the in-band loop code block.
`timescale 1ns/1ps
module inband_loop_code_gen_detect_test;
  import ilc_pkg::*;
  localparam int         INTEG = 2000;
  localparam logic [7:0] CLEAN [8] = '{8'h80, 8'h80, 8'hc0, 8'hd0, 8'hd0, 8'hd0, 8'hd8, 8'hd4};
  logic        clk_sys       = 1'b0;
  logic        rst_b         = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'h1;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        txPcmData     = 1'b0;
  logic        txBitStrobe   = 1'b0;
  logic        txFramingSlot = 1'b0;
  logic        txFramingBit  = 1'b0;
  logic [7:0]  codeByte      = 8'h80;
  logic [3:0]  codeLen       = 4'h1;
  logic [7:0]  errEvery      = 8'h00;
  logic        corrupt       = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        rxLineData, rxBitStrobe, txLineData, irq;
  int          n_errors      = 0;
  int          checks        = 0;
  int          cyc           = 0;

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  ilc_top #(.INTEG_CYCLES(INTEG)) ilc_top_i (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .txPcmData, .txBitStrobe, .txFramingSlot, .txFramingBit, .rxLineData, .rxBitStrobe, .txLineData, .irq);
  ilc_remote_end ilc_remote_end_i (.clk_sys, .rst_b, .codeByte, .codeLen, .errEvery, .corrupt,
    .rxLineData, .rxBitStrobe);

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic guard(input int n);
    if (n > 4000)
    begin
      n_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      test_done();
    end
  endtask : guard

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      guard(n);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      guard(n);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, e, "register");
    check(32'(r), 32'(ILC_RESP_OKAY), "read response");
  endtask : rchk

  // Polls the status register, so the returned cycle trails the event by two reads at most.
  task automatic waitst(output int t);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do
    begin
      rd(8'h5c, d, r);
      n++;
      guard(n);
    end
    while (d[1:0] === 2'h0);
    t = cyc;
  endtask : waitst

  task automatic txbit(input logic slot, input logic fb, input logic pcm, output logic seen);
    txFramingSlot <= slot;
    txFramingBit  <= fb;
    txPcmData     <= pcm;
    txBitStrobe   <= 1'b1;
    @(posedge clk_sys);
    txBitStrobe   <= 1'b0;
    txFramingSlot <= 1'b0;
    @(posedge clk_sys);
    seen = txLineData;
  endtask : txbit

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++)
      rchk(8'h48 + 8'(4 * i), 32'h0);
    wreg(8'h4c, 8'h5a);
    wreg(8'h50, 8'ha5);
    wreg(8'h54, 8'h3c);
    rchk(8'h4c, 32'h5a);
    rchk(8'h50, 32'ha5);
    rchk(8'h54, 32'h3c);
    s_axi_wstrb <= 4'h0;
    wreg(8'h4c, 8'hff);
    s_axi_wstrb <= 4'h1;
    rchk(8'h4c, 32'h5a);
    wr(8'h70, 8'hff, r);
    check(32'(r), 32'(ILC_RESP_SLVERR), "unmapped write");
    rd(8'h4d, d, r);
    check(32'(r), 32'(ILC_RESP_SLVERR), "unaligned read");
    check(d, 32'h0, "refused data");
  endtask : t_regs

  task automatic t_tx();
    logic [7:0] pat;
    logic       fdis;
    logic       exp;
    logic       seen;
    int         len;
    pat = 8'hb5;
    wreg(8'h4c, pat);
    for (int s = 0; s < 4; s++)
    begin
      len  = 5 + s;
      fdis = (s == 3);
      wreg(8'h58, 8'h00);
      wreg(8'h48, {2'(s), 6'h00});
      wreg(8'h58, {6'h00, fdis, 1'b1});
      for (int i = 0; i < 2 * len; i++)
      begin
        exp = pat[7 - (i % len)];
        txbit(i == 3, ~exp, ~exp, seen);
        check(32'(seen), 32'((i == 3 && !fdis) ^ exp), "line bit");
      end
    end
    wreg(8'h58, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      txbit(1'b0, 1'b0, i[0], seen);
      check(32'(seen), 32'(i[0]), "idle data");
    end
  endtask : t_tx

  task automatic t_rx(input logic dn, input int len);
    logic [7:0] clean;
    int         t;
    clean = CLEAN[len - 1];
    codeByte <= clean;
    codeLen  <= 4'(len);
    wreg(dn ? 8'h50 : 8'h54, 8'h00);
    wreg(dn ? 8'h54 : 8'h50, clean | (8'hff >> len));
    wreg(8'h48, dn ? 8'(len - 1) : 8'((len - 1) << 3));
    repeat (50) @(posedge clk_sys);
    wreg(8'h5c, 8'h03);
    waitst(t);
    rchk(8'h5c, dn ? 32'h2 : 32'h1);
    rchk(8'h64, dn ? 32'h2 : 32'h1);
  endtask : t_rx

  task automatic t_integ();
    int t1;
    int t2;
    int t3;
    errEvery <= 8'h96;
    wreg(8'h60, 8'h01);
    wreg(8'h5c, 8'h03);
    waitst(t1);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h1, "irq raised");
    wreg(8'h5c, 8'h01);
    rchk(8'h5c, 32'h0);
    check(32'(irq), 32'h0, "irq cleared");
    waitst(t2);
    check(32'((t2 - t1 > INTEG - 10) && (t2 - t1 < INTEG + 10)), 32'h1, "integration");
    wreg(8'h60, 8'h00);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h0, "irq masked");
    wreg(8'h5c, 8'h01);
    repeat (1000) @(posedge clk_sys);
    corrupt <= 1'b1;
    repeat (60) @(posedge clk_sys);
    rchk(8'h64, 32'h0);
    corrupt <= 1'b0;
    waitst(t3);
    check(32'(t3 - t2 > INTEG + 1000), 32'h1, "restart");
    errEvery <= 8'h00;
  endtask : t_integ

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_tx();
    for (int l = 1; l <= 8; l++)
      t_rx(1'b0, l);
    t_integ();
    for (int l = 1; l <= 8; l++)
      t_rx(1'b1, l);
    test_done();
  end
endmodule : inband_loop_code_gen_detect_test
